// [design/dma_pkg.sv]
// Shared constants and types for the descriptor list DMA engine and its host end.
package dma_pkg;
   // Descriptor list header fields, fragment limit, address steps and descriptor word indices.
   localparam int LEN_LSB = 0;
   localparam int LEN_MSB = 15;
   localparam int CNT_LSB = 16;
   localparam int CNT_MSB = 20;
   localparam int OPT_LSB = 21;
   localparam int OPT_MSB = 30;
   localparam int IRQ_BIT = 31;
   localparam int FRAG_MAX = 31;
   localparam logic [63:0] WORD_STEP = 64'h4;
   localparam logic [63:0] DESC_STEP = 64'h10;
   localparam logic [15:0] WORD_BYTES = 16'h4;
   localparam logic [1:0] SUB_LSD = 2'h0;
   localparam logic [1:0] SUB_MSD = 2'h1;
   localparam logic [1:0] SUB_LEN = 2'h2;
   // Storage sizes.
   localparam int TXF_AW = 5;
   localparam int TXF_DEPTH = 32;
   localparam int RXF_AW = 5;
   localparam int RXF_DEPTH = 32;
   localparam int CMDF_AW = 2;
   localparam int CMDF_DEPTH = 4;
   localparam int MEM_AW = 6;
   localparam int MEM_WORDS = 64;
   // Host end register offsets and status bit positions.
   localparam logic [7:0] A_MEM_ADDR = 8'h00;
   localparam logic [7:0] A_MEM_DATA = 8'h04;
   localparam logic [7:0] A_PIO_LEN = 8'h08;
   localparam logic [7:0] A_PIO_DATA = 8'h0c;
   localparam logic [7:0] A_PIO_DONE = 8'h10;
   localparam logic [7:0] A_TX_HI = 8'h14;
   localparam logic [7:0] A_TX_LO = 8'h18;
   localparam logic [7:0] A_RX_HI = 8'h1c;
   localparam logic [7:0] A_RX_LO = 8'h20;
   localparam logic [7:0] A_STATUS = 8'h24;
   localparam logic [7:0] A_MASK = 8'h28;
   localparam logic [7:0] A_INFO = 8'h2c;
   localparam int ST_DONE = 0;
   localparam int ST_REFUSED = 1;
   localparam int ST_W = 2;

   typedef enum logic [3:0] {
      E_IDLE      = 4'b0000,
      E_HDR_REQ   = 4'b0001,
      E_HDR_WAIT  = 4'b0010,
      E_DESC_REQ  = 4'b0011,
      E_DESC_WAIT = 4'b0100,
      E_EXEC      = 4'b0101,
      E_DATA_REQ  = 4'b0110,
      E_DATA_WAIT = 4'b0111,
      E_FINISH    = 4'b1000
   } eng_state_e;
endpackage : dma_pkg

// [design/dma_link.sv]
// Link between the host end (CPU and memory) and the DMA engine.
`timescale 1ns/10ps
interface dma_link;
   logic        pio_wr;
   logic [31:0] pio_data;
   logic        pio_done;
   logic [5:0]  tx_free;
   logic        busy_tx;
   logic        cmd_wr;
   logic        cmd_rx;
   logic        cmd_hi;
   logic [31:0] cmd_data;
   logic        mem_req;
   logic        mem_we;
   logic [63:0] mem_addr;
   logic [31:0] mem_wdata;
   logic        mem_ack;
   logic [31:0] mem_rdata;
   logic        transfer_done_irq_request;

   modport dev (input pio_wr, pio_data, pio_done, cmd_wr, cmd_rx, cmd_hi, cmd_data,
                mem_ack, mem_rdata,
                output tx_free, busy_tx, mem_req, mem_we, mem_addr, mem_wdata,
                transfer_done_irq_request);
   modport host (output pio_wr, pio_data, pio_done, cmd_wr, cmd_rx, cmd_hi, cmd_data,
                 mem_ack, mem_rdata,
                 input tx_free, busy_tx, mem_req, mem_we, mem_addr, mem_wdata,
                 transfer_done_irq_request);
endinterface : dma_link

// [design/dma_engine.sv]
// Device end: command FIFOs, bus master controller and transmit/receive data FIFOs.
`timescale 1ns/10ps
module dma_engine (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Link to the host end
   dma_link.dev             link,
   // Transmit side of the MAC
   input  wire logic        mac_rd_in,
   output logic [31:0]      mac_data_out,
   output logic             mac_valid_out,
   output logic             tx_pkt_ready_out,
   output logic [9:0]       per_packet_tx_options_out,
   // Receive side of the MAC
   input  wire logic [31:0] rx_data_in,
   input  wire logic        rx_valid_in,
   input  wire logic        rx_last_in,
   output logic             rx_ready_out
);
   typedef struct packed {
      logic [dma_pkg::CMDF_DEPTH-1:0][63:0]    txc;
      logic [dma_pkg::CMDF_AW:0]               txc_wp;
      logic [dma_pkg::CMDF_AW:0]               txc_rp;
      logic [dma_pkg::CMDF_DEPTH-1:0][63:0]    rxc;
      logic [dma_pkg::CMDF_AW:0]               rxc_wp;
      logic [dma_pkg::CMDF_AW:0]               rxc_rp;
      logic [31:0]                             tx_hi;
      logic [31:0]                             rx_hi;
      dma_pkg::eng_state_e                     st;
      logic                                    dir_rx;
      logic [63:0]                             list_ptr;
      logic [31:0]                             hdr;
      logic [4:0]                              fragment_count;
      logic [4:0]                              fi;
      logic [1:0]                              sub;
      logic [dma_pkg::FRAG_MAX-1:0][63:0]      fragment_address;
      logic [dma_pkg::FRAG_MAX-1:0][15:0]      fragment_length;
      logic [63:0]                             cur;
      logic [15:0]                             left;
      logic [15:0]                             tot;
      logic [dma_pkg::TXF_DEPTH-1:0][31:0]     txf;
      logic [dma_pkg::TXF_AW:0]                txf_wp;
      logic [dma_pkg::TXF_AW:0]                txf_rp;
      logic [dma_pkg::TXF_AW:0]                ready_words;
      logic [dma_pkg::TXF_AW:0]                pend_words;
      logic [dma_pkg::RXF_DEPTH-1:0][31:0]     rxf;
      logic [dma_pkg::RXF_AW:0]                rxf_wp;
      logic [dma_pkg::RXF_AW:0]                rxf_rp;
      logic [dma_pkg::RXF_AW:0]                rx_pkts;
      logic                                    mem_req;
      logic                                    mem_we;
      logic [63:0]                             mem_addr;
      logic [31:0]                             mem_wdata;
      logic                                    irq;
      logic [31:0]                             mac_data;
      logic                                    mac_valid;
      logic                                    pkt_ready;
      logic [9:0]                              opts;
   } eng_s;

   eng_s r;
   eng_s n;

   logic txc_full;
   logic rxc_full;
   logic txf_full;
   logic rxf_full;
   logic tx_dma;

   assign txc_full = (r.txc_wp - r.txc_rp) == 3'(dma_pkg::CMDF_DEPTH);
   assign rxc_full = (r.rxc_wp - r.rxc_rp) == 3'(dma_pkg::CMDF_DEPTH);
   assign txf_full = (r.txf_wp - r.txf_rp) == 6'(dma_pkg::TXF_DEPTH);
   assign rxf_full = (r.rxf_wp - r.rxf_rp) == 6'(dma_pkg::RXF_DEPTH);
   // Programmed I/O is locked out while a transmit list owns the FIFO write pointer.
   assign tx_dma   = (r.st != dma_pkg::E_IDLE) && !r.dir_rx;

   always_comb begin
      n = r;
      n.mem_req   = 1'b0;
      n.irq       = 1'b0;
      n.mac_valid = 1'b0;
      n.pkt_ready = 1'b0;
      // Address register pair: the lower dword completes and queues the command.
      if (link.cmd_wr) begin
         if (link.cmd_hi) begin
            if (link.cmd_rx) begin
               n.rx_hi = link.cmd_data;
            end else begin
               n.tx_hi = link.cmd_data;
            end
         end else if (link.cmd_rx) begin
            if (!rxc_full) begin
               n.rxc[r.rxc_wp[dma_pkg::CMDF_AW-1:0]] = {r.rx_hi, link.cmd_data};
               n.rxc_wp = r.rxc_wp + 1'b1;
            end
         end else if (!txc_full) begin
            n.txc[r.txc_wp[dma_pkg::CMDF_AW-1:0]] = {r.tx_hi, link.cmd_data};
            n.txc_wp = r.txc_wp + 1'b1;
         end
      end
      // Receive stream from the MAC; whole packets are counted.
      if (rx_valid_in && !rxf_full) begin
         n.rxf[r.rxf_wp[dma_pkg::RXF_AW-1:0]] = rx_data_in;
         n.rxf_wp = r.rxf_wp + 1'b1;
         if (rx_last_in) begin
            n.rx_pkts = n.rx_pkts + 1'b1;
         end
      end
      // Programmed I/O words and packet completion.
      if (link.pio_wr && !txf_full && !tx_dma) begin
         n.txf[r.txf_wp[dma_pkg::TXF_AW-1:0]] = link.pio_data;
         n.txf_wp = r.txf_wp + 1'b1;
         n.pend_words = n.pend_words + 1'b1;
      end
      if (link.pio_done && !tx_dma) begin
         n.ready_words = n.ready_words + n.pend_words;
         n.pend_words = '0;
         n.pkt_ready = 1'b1;
      end
      // The MAC drains committed words only.
      if (mac_rd_in && (r.ready_words != '0)) begin
         n.mac_data = r.txf[r.txf_rp[dma_pkg::TXF_AW-1:0]];
         n.mac_valid = 1'b1;
         n.txf_rp = r.txf_rp + 1'b1;
         n.ready_words = n.ready_words - 1'b1;
      end
      unique case (r.st)
         dma_pkg::E_IDLE: begin
            // Transmit commands are served ahead of receive commands.
            if (r.txc_wp != r.txc_rp) begin
               n.list_ptr = r.txc[r.txc_rp[dma_pkg::CMDF_AW-1:0]];
               n.txc_rp = r.txc_rp + 1'b1;
               n.dir_rx = 1'b0;
               n.st = dma_pkg::E_HDR_REQ;
            end else if ((r.rxc_wp != r.rxc_rp) && (r.rx_pkts != '0)) begin
               n.list_ptr = r.rxc[r.rxc_rp[dma_pkg::CMDF_AW-1:0]];
               n.rxc_rp = r.rxc_rp + 1'b1;
               n.dir_rx = 1'b1;
               n.st = dma_pkg::E_HDR_REQ;
            end
         end
         dma_pkg::E_HDR_REQ: begin
            n.mem_req = 1'b1;
            n.mem_we = 1'b0;
            n.mem_addr = r.list_ptr;
            n.st = dma_pkg::E_HDR_WAIT;
         end
         dma_pkg::E_HDR_WAIT: begin
            if (link.mem_ack) begin
               n.hdr = link.mem_rdata;
               n.tot = link.mem_rdata[dma_pkg::LEN_MSB:dma_pkg::LEN_LSB];
               n.fragment_count = link.mem_rdata[dma_pkg::CNT_MSB:dma_pkg::CNT_LSB];
               n.opts = link.mem_rdata[dma_pkg::OPT_MSB:dma_pkg::OPT_LSB];
               n.list_ptr = r.list_ptr + dma_pkg::WORD_STEP;
               n.fi = '0;
               n.sub = dma_pkg::SUB_LSD;
               n.st = (n.fragment_count == '0) ? dma_pkg::E_FINISH : dma_pkg::E_DESC_REQ;
            end
         end
         dma_pkg::E_DESC_REQ: begin
            n.mem_req = 1'b1;
            n.mem_we = 1'b0;
            n.mem_addr = r.list_ptr + {60'h0, r.sub, 2'h0};
            n.st = dma_pkg::E_DESC_WAIT;
         end
         dma_pkg::E_DESC_WAIT: begin
            if (link.mem_ack) begin
               unique case (r.sub)
                  dma_pkg::SUB_LSD: n.fragment_address[r.fi][31:0] = link.mem_rdata;
                  dma_pkg::SUB_MSD: n.fragment_address[r.fi][63:32] = link.mem_rdata;
                  default: n.fragment_length[r.fi] =
                     link.mem_rdata[dma_pkg::LEN_MSB:dma_pkg::LEN_LSB];
               endcase
               n.st = dma_pkg::E_DESC_REQ;
               n.sub = r.sub + 1'b1;
               // The reserved fourth word is never fetched.
               if (r.sub == dma_pkg::SUB_LEN) begin
                  n.sub = dma_pkg::SUB_LSD;
                  n.list_ptr = r.list_ptr + dma_pkg::DESC_STEP;
                  n.fi = r.fi + 1'b1;
                  if (r.fi == r.fragment_count - 1'b1) begin
                     n.fi = '0;
                     n.st = dma_pkg::E_EXEC;
                  end
               end
            end
         end
         dma_pkg::E_EXEC: begin
            n.cur = r.fragment_address[r.fi];
            n.left = r.fragment_length[r.fi];
            n.st = dma_pkg::E_DATA_REQ;
            if (r.fragment_length[r.fi] == '0) begin
               n.fi = r.fi + 1'b1;
               n.st = dma_pkg::E_EXEC;
               if (r.fi == r.fragment_count - 1'b1) begin
                  n.st = dma_pkg::E_FINISH;
               end
            end
         end
         dma_pkg::E_DATA_REQ: begin
            if (!r.dir_rx && !txf_full) begin
               n.mem_req = 1'b1;
               n.mem_we = 1'b0;
               n.mem_addr = r.cur;
               n.st = dma_pkg::E_DATA_WAIT;
            end else if (r.dir_rx && (r.rxf_wp != r.rxf_rp)) begin
               n.mem_req = 1'b1;
               n.mem_we = 1'b1;
               n.mem_addr = r.cur;
               n.mem_wdata = r.rxf[r.rxf_rp[dma_pkg::RXF_AW-1:0]];
               n.rxf_rp = r.rxf_rp + 1'b1;
               n.st = dma_pkg::E_DATA_WAIT;
            end
         end
         dma_pkg::E_DATA_WAIT: begin
            if (link.mem_ack) begin
               if (!r.dir_rx) begin
                  n.txf[r.txf_wp[dma_pkg::TXF_AW-1:0]] = link.mem_rdata;
                  n.txf_wp = r.txf_wp + 1'b1;
                  n.pend_words = n.pend_words + 1'b1;
               end
               n.cur = r.cur + dma_pkg::WORD_STEP;
               n.left = (r.left <= dma_pkg::WORD_BYTES) ? '0 : r.left - dma_pkg::WORD_BYTES;
               n.tot = (r.tot <= dma_pkg::WORD_BYTES) ? '0 : r.tot - dma_pkg::WORD_BYTES;
               n.st = dma_pkg::E_DATA_REQ;
               if (n.tot == '0) begin
                  n.st = dma_pkg::E_FINISH;
               end else if (n.left == '0) begin
                  n.fi = r.fi + 1'b1;
                  n.st = dma_pkg::E_EXEC;
                  if (r.fi == r.fragment_count - 1'b1) begin
                     n.st = dma_pkg::E_FINISH;
                  end
               end
            end
         end
         dma_pkg::E_FINISH: begin
            if (!r.dir_rx) begin
               n.ready_words = n.ready_words + n.pend_words;
               n.pend_words = '0;
               n.pkt_ready = 1'b1;
            end else begin
               n.rx_pkts = n.rx_pkts - 1'b1;
            end
            n.irq = r.hdr[dma_pkg::IRQ_BIT];
            n.st = dma_pkg::E_IDLE;
         end
         default: n.st = dma_pkg::E_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign link.tx_free = 6'(dma_pkg::TXF_DEPTH) - (r.txf_wp - r.txf_rp);
   assign link.busy_tx = tx_dma;
   assign link.mem_req = r.mem_req;
   assign link.mem_we = r.mem_we;
   assign link.mem_addr = r.mem_addr;
   assign link.mem_wdata = r.mem_wdata;
   assign link.transfer_done_irq_request = r.irq;
   assign mac_data_out = r.mac_data;
   assign mac_valid_out = r.mac_valid;
   assign tx_pkt_ready_out = r.pkt_ready;
   assign per_packet_tx_options_out = r.opts;
   assign rx_ready_out = !rxf_full;
endmodule : dma_engine

// [design/dma_host.sv]
// Host end: CPU register port, system memory and the programmed I/O gate.
`timescale 1ns/10ps
module dma_host (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Software register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,
   output logic             irq_out,
   // Link to the device
   dma_link.host            link
);
   typedef struct packed {
      logic [dma_pkg::MEM_WORDS-1:0][31:0] mem;
      logic [dma_pkg::MEM_AW-1:0]          maddr;
      logic                                pio_open;
      logic [15:0]                         pio_left;
      logic [dma_pkg::ST_W-1:0]            status;
      logic [dma_pkg::ST_W-1:0]            mask;
      logic [31:0]                         rdata;
      logic                                pio_wr;
      logic [31:0]                         pio_data;
      logic                                pio_done;
      logic                                cmd_wr;
      logic                                cmd_rx;
      logic                                cmd_hi;
      logic [31:0]                         cmd_data;
      logic                                mem_ack;
      logic [31:0]                         mem_rdata;
   } host_s;

   host_s r;
   host_s n;

   always_comb begin
      logic [dma_pkg::ST_W-1:0] ev;
      logic [dma_pkg::ST_W-1:0] clr;
      logic [15:0]              words;
      ev = '0;
      clr = '0;
      words = {2'h0, wdata_in[15:2]} + {15'h0, |wdata_in[1:0]};
      n = r;
      n.pio_wr = 1'b0;
      n.pio_done = 1'b0;
      n.cmd_wr = 1'b0;
      n.mem_ack = 1'b0;
      if (wr_in) begin
         unique case (addr_in)
            dma_pkg::A_MEM_ADDR: n.maddr = wdata_in[dma_pkg::MEM_AW-1:0];
            dma_pkg::A_MEM_DATA: begin
               n.mem[r.maddr] = wdata_in;
               n.maddr = r.maddr + 1'b1;
            end
            dma_pkg::A_PIO_LEN: begin
               // A packet that cannot fit is refused before any word moves.
               if ((words <= {10'h0, link.tx_free}) && !link.busy_tx) begin
                  n.pio_open = 1'b1;
                  n.pio_left = words;
               end else begin
                  n.pio_open = 1'b0;
                  ev[dma_pkg::ST_REFUSED] = 1'b1;
               end
            end
            dma_pkg::A_PIO_DATA: begin
               if (r.pio_open && (r.pio_left != '0)) begin
                  n.pio_wr = 1'b1;
                  n.pio_data = wdata_in;
                  n.pio_left = r.pio_left - 1'b1;
               end
            end
            dma_pkg::A_PIO_DONE: begin
               n.pio_done = r.pio_open;
               n.pio_open = 1'b0;
            end
            dma_pkg::A_TX_HI, dma_pkg::A_TX_LO, dma_pkg::A_RX_HI, dma_pkg::A_RX_LO: begin
               n.cmd_wr = 1'b1;
               n.cmd_rx = (addr_in == dma_pkg::A_RX_HI) || (addr_in == dma_pkg::A_RX_LO);
               n.cmd_hi = (addr_in == dma_pkg::A_TX_HI) || (addr_in == dma_pkg::A_RX_HI);
               n.cmd_data = wdata_in;
            end
            dma_pkg::A_MASK: n.mask = wdata_in[dma_pkg::ST_W-1:0];
            default: n.maddr = r.maddr;
         endcase
      end
      if (rd_in) begin
         unique case (addr_in)
            dma_pkg::A_MEM_ADDR: n.rdata = {26'h0, r.maddr};
            dma_pkg::A_MEM_DATA: n.rdata = r.mem[r.maddr];
            dma_pkg::A_STATUS: begin
               n.rdata = {30'h0, r.status};
               clr = r.status;
            end
            dma_pkg::A_MASK: n.rdata = {30'h0, r.mask};
            dma_pkg::A_INFO: n.rdata = {8'h0, r.pio_left, r.pio_open, link.busy_tx, link.tx_free};
            default: n.rdata = '0;
         endcase
      end
      // Device memory cycles are served after software so the device wins a collision.
      if (link.mem_req) begin
         n.mem_ack = 1'b1;
         if (link.mem_we) begin
            n.mem[link.mem_addr[dma_pkg::MEM_AW+1:2]] = link.mem_wdata;
         end else begin
            n.mem_rdata = r.mem[link.mem_addr[dma_pkg::MEM_AW+1:2]];
         end
      end
      ev[dma_pkg::ST_DONE] = link.transfer_done_irq_request;
      // A new event in the clearing cycle survives the clear.
      n.status = (r.status & ~clr) | ev;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign rdata_out = r.rdata;
   assign irq_out = |(r.status & r.mask);
   assign link.pio_wr = r.pio_wr;
   assign link.pio_data = r.pio_data;
   assign link.pio_done = r.pio_done;
   assign link.cmd_wr = r.cmd_wr;
   assign link.cmd_rx = r.cmd_rx;
   assign link.cmd_hi = r.cmd_hi;
   assign link.cmd_data = r.cmd_data;
   assign link.mem_ack = r.mem_ack;
   assign link.mem_rdata = r.mem_rdata;
endmodule : dma_host

// [tb/dma_link_props.sv]
// Concurrent checks on the link that joins the host end and the DMA engine.
`timescale 1ns/10ps
module dma_link_props (
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        rst_in,
   // Link signals
   input wire logic        pio_wr,
   input wire logic [5:0]  tx_free,
   input wire logic        busy_tx,
   input wire logic        cmd_wr,
   input wire logic        cmd_rx,
   input wire logic        cmd_hi,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [63:0] mem_addr,
   input wire logic        mem_ack,
   input wire logic        transfer_done_irq_request
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence tx_push_s;
      cmd_wr && !cmd_hi && !cmd_rx && !busy_tx && !mem_req;
   endsequence
   sequence fetch_s;
      ##[1:6] mem_req ##[2:4] mem_req;
   endsequence
   ack_follows_a: assert property (mem_req |=> mem_ack)
      else $error("memory request left unanswered");
   one_outst_a: assert property (mem_req |=> !mem_req)
      else $error("second memory request while one is open");
   fetch_start_a: assert property (tx_push_s |-> fetch_s)
      else $error("queued list not fetched promptly");
   free_dec_a: assert property (pio_wr && !busy_tx && tx_free != 6'h0
      |=> tx_free == $past(tx_free) - 6'h1)
      else $error("accepted word did not take one free slot");
   free_cap_a: assert property (tx_free <= 6'h20)
      else $error("free space above fifo depth");
   irq_pulse_a: assert property (transfer_done_irq_request |=> !transfer_done_irq_request)
      else $error("completion request longer than one cycle");
   tx_read_only_a: assert property (busy_tx && mem_req |-> !mem_we)
      else $error("memory write during transmit list");
   word_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
      else $error("unaligned memory request");
endmodule : dma_link_props

// [tb/descriptor_list_dma_engine_tb_top.sv]
// Self-checking bench for the host end and the DMA engine joined by their link.
`timescale 1ns/10ps
module descriptor_list_dma_engine_tb_top;
   logic        clk_in, rst_in, wr_in, rd_in, irq_out, mac_rd_in, mac_valid_out;
   logic        tx_pkt_ready_out, rx_valid_in, rx_last_in, rx_ready_out, irq_b;
   logic [7:0]  addr_in;
   logic [9:0]  opts;
   logic [31:0] wdata_in, rdata_out, mac_data_out, rx_data_in, seed, rd_v, w, n, r0, r1;
   logic [31:0] exp_q[$];
   int          n_mismatch, total_checks, n_ready;
   dma_link link ();
   dma_host u_dma_host (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .irq_out(irq_out), .link(link));
   dma_engine u_dma_engine (.clk_in(clk_in), .rst_in(rst_in), .link(link),
      .mac_rd_in(mac_rd_in), .mac_data_out(mac_data_out), .mac_valid_out(mac_valid_out),
      .tx_pkt_ready_out(tx_pkt_ready_out), .per_packet_tx_options_out(opts),
      .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in), .rx_last_in(rx_last_in),
      .rx_ready_out(rx_ready_out));
   dma_link_props u_dma_link_props (.clk_in(clk_in), .rst_in(rst_in), .pio_wr(link.pio_wr),
      .tx_free(link.tx_free), .busy_tx(link.busy_tx), .cmd_wr(link.cmd_wr),
      .cmd_rx(link.cmd_rx), .cmd_hi(link.cmd_hi), .mem_req(link.mem_req),
      .mem_we(link.mem_we), .mem_addr(link.mem_addr), .mem_ack(link.mem_ack),
      .transfer_done_irq_request(link.transfer_done_irq_request));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 rd_v = rdata_out;
   endtask : rd
   task automatic pop_all();
      while (exp_q.size() > 0) begin
         @(posedge clk_in);
         mac_rd_in <= 1'b1;
         @(posedge clk_in);
         mac_rd_in <= 1'b0;
         #1 chk("mac valid", {31'h0, mac_valid_out}, 32'h1);
         chk("mac word", mac_data_out, exp_q.pop_front());
      end
   endtask : pop_all
   task automatic wait_ready(input int t);
      for (int k = 0; k < 400 && n_ready < t; k++) @(posedge clk_in);
      chk("packets", n_ready, t);
   endtask : wait_ready
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   always @(posedge clk_in) if (tx_pkt_ready_out === 1'b1) n_ready++;
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      n_mismatch++;
      close_out();
   end
   initial begin
      {rst_in, seed} = {1'b1, 32'h5c1e8fde};
      {wr_in, rd_in, mac_rd_in, rx_valid_in, rx_last_in} = 5'h0;
      {addr_in, wdata_in, rx_data_in} = 72'h0;
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      n = 32'h1 + (xs() % 32'h8);
      wr(dma_pkg::A_PIO_LEN, n * 32'h4);
      for (int k = 0; k < n; k++) begin
         w = xs();
         exp_q.push_back(w);
         wr(dma_pkg::A_PIO_DATA, w);
      end
      rd(dma_pkg::A_INFO);
      chk("free words", {26'h0, rd_v[5:0]}, 32'h20 - n);
      wr(dma_pkg::A_PIO_DONE, 32'h0);
      wait_ready(1);
      pop_all();
      wr(dma_pkg::A_PIO_LEN, 32'h84);
      rd(dma_pkg::A_STATUS);
      chk("pio refused", rd_v, 32'h2);
      $display("test pio finished");
      wr(dma_pkg::A_MASK, 32'h1);
      for (int i = 0; i < 2; i++) begin
         irq_b = (i == 1);
         w = xs();
         wr(dma_pkg::A_MEM_ADDR, 32'h0);
         wr(dma_pkg::A_MEM_DATA, {irq_b, w[9:0], 5'h02, 16'h000c});
         for (int f = 0; f < 2; f++) begin
            wr(dma_pkg::A_MEM_DATA, (f == 0) ? 32'h40 : 32'h60);
            wr(dma_pkg::A_MEM_DATA, xs());
            r0 = xs();
            wr(dma_pkg::A_MEM_DATA, {r0[31:16], (f == 0) ? 16'h8 : 16'h4});
            wr(dma_pkg::A_MEM_DATA, xs());
         end
         wr(dma_pkg::A_MEM_ADDR, 32'h10);
         for (int k = 0; k < 3; k++) begin
            if (k == 2) wr(dma_pkg::A_MEM_ADDR, 32'h18);
            r0 = xs();
            exp_q.push_back(r0);
            wr(dma_pkg::A_MEM_DATA, r0);
         end
         wr(dma_pkg::A_TX_HI, 32'h0);
         wr(dma_pkg::A_TX_LO, 32'h0);
         wait_ready(2 + i);
         repeat (2) @(posedge clk_in);
         chk("options", {22'h0, opts}, {22'h0, w[9:0]});
         chk("irq level", {31'h0, irq_out}, {31'h0, irq_b});
         rd(dma_pkg::A_STATUS);
         chk("status", rd_v, {31'h0, irq_b});
         rd(dma_pkg::A_STATUS);
         chk("status cleared", rd_v, 32'h0);
         chk("irq cleared", {31'h0, irq_out}, 32'h0);
         pop_all();
         $display("test list %0d finished", i);
      end
      wr(dma_pkg::A_MEM_ADDR, 32'h28);
      wr(dma_pkg::A_MEM_DATA, 32'h0);
      {r0, r1} = {xs(), xs()};
      @(posedge clk_in);
      {rx_valid_in, rx_data_in} <= {1'b1, r0};
      @(posedge clk_in);
      {rx_last_in, rx_data_in} <= {1'b1, r1};
      @(posedge clk_in);
      {rx_valid_in, rx_last_in} <= 2'h0;
      repeat (30) @(posedge clk_in);
      wr(dma_pkg::A_MEM_ADDR, 32'h28);
      rd(dma_pkg::A_MEM_DATA);
      chk("rx held", rd_v, 32'h0);
      wr(dma_pkg::A_MEM_ADDR, 32'h30);
      wr(dma_pkg::A_MEM_DATA, {16'h0001, 16'h0008});
      wr(dma_pkg::A_MEM_DATA, 32'ha0);
      wr(dma_pkg::A_MEM_DATA, 32'h0);
      wr(dma_pkg::A_MEM_DATA, 32'h8);
      wr(dma_pkg::A_RX_HI, 32'h0);
      wr(dma_pkg::A_RX_LO, 32'hc0);
      repeat (60) @(posedge clk_in);
      for (int k = 0; k < 2; k++) begin
         wr(dma_pkg::A_MEM_ADDR, 32'h28 + k);
         rd(dma_pkg::A_MEM_DATA);
         chk("rx word", rd_v, (k == 0) ? r0 : r1);
      end
      chk("rx ready", {31'h0, rx_ready_out}, 32'h1);
      rd(8'hfc);
      chk("unmapped read", rd_v, 32'h0);
      $display("test rx finished");
      close_out();
   end
endmodule : descriptor_list_dma_engine_tb_top
